// ==== logic/pwg_command_write_guard.sv ====
// Purpose: per-group write locks, access-code gate and fixed tag word
// Assumes: command strobes come from the bus decoder on clk_sys
// Notes:   nonvolatile load strobe serves both boot and restore
module pwg_command_write_guard #(
   parameter int LOCK_W = pwg_pkg::LOCK_W,
   parameter int DATA_W = pwg_pkg::DATA_W,
   parameter logic [15:0] TAG_VALUE = pwg_pkg::TAG_DEFAULT
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // command strobe from the bus decoder
   input wire logic cmdValid,
   input wire logic cmdWrite,
   input wire logic [7:0] cmdCode,
   input wire logic [DATA_W-1:0] cmdData,
   // live standard write-protect level
   input wire logic [7:0] protectLevel,
   // nonvolatile backup load (boot or restore)
   input wire logic nvmLoad,
   input wire logic [LOCK_W-1:0] nvmLockWord,
   input wire logic [DATA_W-1:0] nvmKeyWord,
   // answer to the bus decoder
   output logic ackValid,
   output logic writeGrant,
   output logic writeRefused,
   output logic [DATA_W-1:0] readData,
   // state seen by the rest of the device
   output logic [LOCK_W-1:0] lockBits,
   output logic keyOpen,
   output logic bootDone
);
   // ---------------------------------------------------------------
   // elaboration checks
   // ---------------------------------------------------------------
   if (LOCK_W != pwg_pkg::LOCK_W) begin : g_bad_lock
      $error("lock width must match the nine decoded groups");
   end
   if (DATA_W != pwg_pkg::DATA_W) begin : g_bad_data
      $error("data width must be one sixteen-bit word");
   end

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   pwg_pkg::pwg_state_t state_reg;
   logic [LOCK_W-1:0] lock_reg;
   logic [DATA_W-1:0] bootKey_reg;
   logic [DATA_W-1:0] activeKey_reg;
   logic keyOpen_reg;
   logic ack_reg;
   logic grant_reg;
   logic refuse_reg;
   logic [DATA_W-1:0] rdData_reg;
   logic bootDone_reg;

   // ---------------------------------------------------------------
   // decode
   // ---------------------------------------------------------------
   logic [LOCK_W-1:0] groupHit;
   logic isLockCmd;
   logic isTagCmd;
   logic stdBlocked;
   logic lockHit;
   logic allow_next;
   logic hostWrite;
   logic [DATA_W-1:0] rdData_next;

   pwg_group_map u_map (
      .cmdCode(cmdCode),
      .groupHit(groupHit),
      .isLockCmd(isLockCmd),
      .isTagCmd(isTagCmd)
   );

   pwg_std_protect u_std (
      .protectLevel(protectLevel),
      .cmdCode(cmdCode),
      .blocked(stdBlocked)
   );

   // each bit only meets its own group
   assign lockHit = |(groupHit & lock_reg);
   assign hostWrite = cmdValid && cmdWrite && !nvmLoad;

   // ---------------------------------------------------------------
   // write verdict
   // ---------------------------------------------------------------
   // one verdict per strobe; the target acts only on a grant
   always_comb begin
      allow_next = 1'b0;
      // nothing writes before the backup is loaded
      if (state_reg == pwg_pkg::PWG_READY) begin
         if (isTagCmd) begin
            allow_next = 1'b0;
         end else if (isLockCmd) begin
            // lock word needs an open access code
            allow_next = keyOpen_reg;
         end else if (groupHit[pwg_pkg::BIT_KEY]) begin
            // access code frozen by its lock bit, else standard protect
            allow_next = !lock_reg[pwg_pkg::BIT_KEY] && !stdBlocked;
         end else if (groupHit[pwg_pkg::BIT_SAVE]) begin
            // save also needs protect and code clear
            allow_next = !lock_reg[pwg_pkg::BIT_SAVE] && !stdBlocked && keyOpen_reg;
         end else begin
            // group lock on top of standard protect
            allow_next = !lockHit && !stdBlocked;
         end
      end
   end

   // ---------------------------------------------------------------
   // read mux
   // ---------------------------------------------------------------
   // the access code itself is never read back, only its state
   always_comb begin
      rdData_next = pwg_pkg::READ_NONE;
      if (isTagCmd) begin
         rdData_next = TAG_VALUE;
      end else if (isLockCmd) begin
         rdData_next = {{(DATA_W-LOCK_W){1'b0}}, lock_reg};
      end else if (groupHit[pwg_pkg::BIT_KEY]) begin
         rdData_next = keyOpen_reg ? pwg_pkg::KEY_STAT_OPEN : pwg_pkg::KEY_STAT_SHUT;
      end
   end

   // ---------------------------------------------------------------
   // boot sequencing
   // ---------------------------------------------------------------
   // ready only after the backup strobe
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         state_reg <= pwg_pkg::PWG_BOOT;
         bootDone_reg <= 1'b0;
      end else if (nvmLoad) begin
         state_reg <= pwg_pkg::PWG_READY;
         bootDone_reg <= 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // lock word
   // ---------------------------------------------------------------
   // backup load wins over a host write in the same cycle, so a
   // restore can never be half-overwritten
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         lock_reg <= '0;
      end else if (nvmLoad) begin
         // boot and restore both reload the whole lock word
         lock_reg <= nvmLockWord;
      end else if (hostWrite && isLockCmd && allow_next) begin
         // after boot with a nonzero code this path stays shut until that code is matched
         lock_reg <= cmdData[LOCK_W-1:0];
      end
   end

   // ---------------------------------------------------------------
   // access code
   // ---------------------------------------------------------------
   // the boot copy is what unlocks; an open code takes new values
   // that only matter once stored and rebooted
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         bootKey_reg <= pwg_pkg::KEY_ZERO;
         activeKey_reg <= pwg_pkg::KEY_ZERO;
         keyOpen_reg <= 1'b0;
      end else if (nvmLoad && state_reg == pwg_pkg::PWG_BOOT) begin
         bootKey_reg <= nvmKeyWord;
         activeKey_reg <= nvmKeyWord;
         keyOpen_reg <= (nvmKeyWord == pwg_pkg::KEY_ZERO);
      end else if (hostWrite && groupHit[pwg_pkg::BIT_KEY] && allow_next) begin
         // reached only while the key lock bit is clear
         if (keyOpen_reg) begin
            activeKey_reg <= cmdData;
         end else if (cmdData == bootKey_reg) begin
            keyOpen_reg <= 1'b1;
         end
      end
   end

   // ---------------------------------------------------------------
   // answer
   // ---------------------------------------------------------------
   // every strobe is answered one cycle later, reads and writes alike
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         ack_reg <= 1'b0;
         grant_reg <= 1'b0;
         refuse_reg <= 1'b0;
      end else begin
         ack_reg <= cmdValid;
         // no grant, so the target keeps its value
         grant_reg <= cmdValid && cmdWrite && allow_next;
         // tag writes never count as refused
         refuse_reg <= cmdValid && cmdWrite && !allow_next && !isTagCmd;
      end
   end

   // read word held until the next read strobe
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         rdData_reg <= pwg_pkg::READ_NONE;
      end else if (cmdValid && !cmdWrite) begin
         rdData_reg <= rdData_next;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign ackValid = ack_reg;
   assign writeGrant = grant_reg;
   assign writeRefused = refuse_reg;
   assign readData = rdData_reg;
   assign lockBits = lock_reg;
   assign keyOpen = keyOpen_reg;
   assign bootDone = bootDone_reg;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (rst);

   a_tag_read_fixed: assert property (
      cmdValid && !cmdWrite && isTagCmd |=> ackValid && readData == TAG_VALUE)
      else $error("tag read did not return the fixed word");

   a_tag_write_silent: assert property (
      cmdValid && cmdWrite && isTagCmd |=> ackValid && !writeGrant && !writeRefused)
      else $error("tag write was not quietly taken");

   a_boot_no_grant: assert property (
      state_reg == pwg_pkg::PWG_BOOT |=> !writeGrant)
      else $error("write granted before backup load");

   a_locked_group_refused: assert property (
      hostWrite && state_reg == pwg_pkg::PWG_READY && lockHit && !isLockCmd
      |=> writeRefused && !writeGrant)
      else $error("write to locked group was not refused");

   a_open_group_passes: assert property (
      cmdValid && cmdWrite && state_reg == pwg_pkg::PWG_READY && !isTagCmd &&
      !isLockCmd && !(|groupHit[pwg_pkg::BIT_KEY:pwg_pkg::BIT_SAVE]) &&
      !lockHit && !stdBlocked |=> writeGrant)
      else $error("unlocked group write was refused");

   a_margin_bit_guard: assert property (
      cmdValid && cmdWrite && cmdCode == pwg_pkg::CMD_MARGIN_HI &&
      lock_reg[pwg_pkg::BIT_MARGIN] |=> !writeGrant)
      else $error("margin write passed a set lock");

   a_lock_word_shut: assert property (
      hostWrite && isLockCmd && !keyOpen_reg |=> $stable(lockBits) && writeRefused)
      else $error("lock word changed while access code shut");

   a_key_frozen: assert property (
      hostWrite && groupHit[pwg_pkg::BIT_KEY] && lock_reg[pwg_pkg::BIT_KEY]
      |=> $stable(activeKey_reg) && $stable(keyOpen) && writeRefused)
      else $error("access code changed while its lock bit set");

   a_save_locked: assert property (
      cmdValid && cmdWrite && groupHit[pwg_pkg::BIT_SAVE] &&
      lock_reg[pwg_pkg::BIT_SAVE] |=> writeRefused && !writeGrant)
      else $error("save granted with its lock bit set");

   a_save_open: assert property (
      cmdValid && cmdWrite && groupHit[pwg_pkg::BIT_SAVE] &&
      state_reg == pwg_pkg::PWG_READY && !lock_reg[pwg_pkg::BIT_SAVE] &&
      !stdBlocked && keyOpen_reg |=> writeGrant)
      else $error("save refused although nothing forbids it");

   a_refused_keeps_lock: assert property (
      !nvmLoad && !(hostWrite && isLockCmd && allow_next) |=> $stable(lockBits))
      else $error("lock word changed without a granted write");
endmodule : pwg_command_write_guard

// ==== logic/pwg_group_map.sv ====
// Purpose: maps a command code onto the lock bit that governs it
// Assumes: one-hot result, all zero for ungoverned commands
// Notes:   purely combinational; the guard registers its decision
module pwg_group_map (
   // command under test
   input wire logic [7:0] cmdCode,
   // decode results
   output logic [pwg_pkg::LOCK_W-1:0] groupHit,
   output logic isLockCmd,
   output logic isTagCmd
);
   // ---------------------------------------------------------------
   // code to group
   // ---------------------------------------------------------------
   // one group per code; codes never overlap between groups
   always_comb begin
      groupHit = '0;
      isLockCmd = (cmdCode == pwg_pkg::CMD_LOCK);
      isTagCmd = (cmdCode == pwg_pkg::CMD_TAG);
      case (cmdCode)
         pwg_pkg::CMD_MARGIN_HI, pwg_pkg::CMD_MARGIN_LO,
         pwg_pkg::CMD_SLEW_RATE: groupHit[pwg_pkg::BIT_MARGIN] = 1'b1;
         pwg_pkg::CMD_RUN_CTRL: groupHit[pwg_pkg::BIT_RUN] = 1'b1;
         pwg_pkg::CMD_FREQ_SWITCH, pwg_pkg::CMD_INTERLEAVE: begin
            groupHit[pwg_pkg::BIT_SETUP] = 1'b1;
         end
         pwg_pkg::CMD_IN_UV_WARN, pwg_pkg::CMD_IN_OV_FAULT,
         pwg_pkg::CMD_IN_OV_WARN, pwg_pkg::CMD_IN_OV_RESP: begin
            groupHit[pwg_pkg::BIT_INPUT] = 1'b1;
         end
         pwg_pkg::CMD_ON_DELAY, pwg_pkg::CMD_ON_RISE, pwg_pkg::CMD_ON_MAX_LIMIT,
         pwg_pkg::CMD_ON_MAX_RESP, pwg_pkg::CMD_OFF_DELAY, pwg_pkg::CMD_OFF_FALL,
         pwg_pkg::CMD_ONOFF_CFG, pwg_pkg::CMD_IN_ON_LEVEL,
         pwg_pkg::CMD_IN_OFF_LEVEL: groupHit[pwg_pkg::BIT_TIMING] = 1'b1;
         pwg_pkg::CMD_MAKER_ID, pwg_pkg::CMD_MAKER_MODEL, pwg_pkg::CMD_MAKER_REV,
         pwg_pkg::CMD_MAKER_SERIAL: groupHit[pwg_pkg::BIT_IDENT] = 1'b1;
         pwg_pkg::CMD_STRAP_BYPASS, pwg_pkg::CMD_BUS_ADDRESS: begin
            groupHit[pwg_pkg::BIT_STRAP] = 1'b1;
         end
         pwg_pkg::CMD_KEY: groupHit[pwg_pkg::BIT_KEY] = 1'b1;
         pwg_pkg::CMD_STORE_ALL: groupHit[pwg_pkg::BIT_SAVE] = 1'b1;
         default: begin
            if (cmdCode >= pwg_pkg::CMD_SETUP_FIRST && cmdCode <= pwg_pkg::CMD_SETUP_LAST) begin
               groupHit[pwg_pkg::BIT_SETUP] = 1'b1;
            end
         end
      endcase
   end
endmodule : pwg_group_map

// ==== logic/pwg_pkg.sv ====
// Purpose: shared constants for the command write guard
// Assumes: command codes are eight bits, data words sixteen bits
// Notes:   vendor configuration codes and strap/address codes are local picks
package pwg_pkg;
   // ---------------------------------------------------------------
   // lock word layout
   // ---------------------------------------------------------------
   localparam int LOCK_W = 9;
   localparam int DATA_W = 16;
   localparam int BIT_MARGIN = 8;
   localparam int BIT_RUN = 7;
   localparam int BIT_SETUP = 6;
   localparam int BIT_INPUT = 5;
   localparam int BIT_TIMING = 4;
   localparam int BIT_IDENT = 3;
   localparam int BIT_STRAP = 2;
   localparam int BIT_KEY = 1;
   localparam int BIT_SAVE = 0;

   // ---------------------------------------------------------------
   // guard-owned command codes
   // ---------------------------------------------------------------
   localparam logic [7:0] CMD_KEY = 8'hFA;
   localparam logic [7:0] CMD_LOCK = 8'hFB;
   localparam logic [7:0] CMD_TAG = 8'hFC;
   localparam logic [7:0] CMD_STORE_ALL = 8'h15;
   localparam logic [7:0] CMD_WRITE_PROTECT = 8'h10;

   // ---------------------------------------------------------------
   // governed command codes, in code order
   // ---------------------------------------------------------------
   localparam logic [7:0] CMD_RUN_CTRL = 8'h01;
   localparam logic [7:0] CMD_ONOFF_CFG = 8'h02;
   localparam logic [7:0] CMD_VOUT_SET = 8'h21;
   localparam logic [7:0] CMD_MARGIN_HI = 8'h25;
   localparam logic [7:0] CMD_MARGIN_LO = 8'h26;
   localparam logic [7:0] CMD_SLEW_RATE = 8'h27;
   localparam logic [7:0] CMD_FREQ_SWITCH = 8'h33;
   localparam logic [7:0] CMD_IN_ON_LEVEL = 8'h35;
   localparam logic [7:0] CMD_IN_OFF_LEVEL = 8'h36;
   localparam logic [7:0] CMD_INTERLEAVE = 8'h37;
   localparam logic [7:0] CMD_IN_OV_FAULT = 8'h55;
   localparam logic [7:0] CMD_IN_OV_RESP = 8'h56;
   localparam logic [7:0] CMD_IN_OV_WARN = 8'h57;
   localparam logic [7:0] CMD_IN_UV_WARN = 8'h58;
   localparam logic [7:0] CMD_ON_DELAY = 8'h60;
   localparam logic [7:0] CMD_ON_RISE = 8'h61;
   localparam logic [7:0] CMD_ON_MAX_LIMIT = 8'h62;
   localparam logic [7:0] CMD_ON_MAX_RESP = 8'h63;
   localparam logic [7:0] CMD_OFF_DELAY = 8'h64;
   localparam logic [7:0] CMD_OFF_FALL = 8'h65;
   localparam logic [7:0] CMD_MAKER_ID = 8'h99;
   localparam logic [7:0] CMD_MAKER_MODEL = 8'h9A;
   localparam logic [7:0] CMD_MAKER_REV = 8'h9B;
   localparam logic [7:0] CMD_MAKER_SERIAL = 8'h9E;
   // vendor setup block: loop, step response, telemetry, stage, output ok,
   // sync, misc, stacking occupy a contiguous range
   localparam logic [7:0] CMD_SETUP_FIRST = 8'hD0;
   localparam logic [7:0] CMD_SETUP_LAST = 8'hD7;
   localparam logic [7:0] CMD_STRAP_BYPASS = 8'hEE;
   localparam logic [7:0] CMD_BUS_ADDRESS = 8'hEF;

   // ---------------------------------------------------------------
   // standard write-protect levels and read answers
   // ---------------------------------------------------------------
   localparam logic [7:0] WP_ALL = 8'h80;
   localparam logic [7:0] WP_KEEP_RUN = 8'h40;
   localparam logic [7:0] WP_KEEP_SET = 8'h20;
   localparam logic [15:0] KEY_ZERO = 16'h0000;
   localparam logic [15:0] KEY_STAT_OPEN = 16'h0000;
   localparam logic [15:0] KEY_STAT_SHUT = 16'h000F;
   localparam logic [15:0] READ_NONE = 16'h0000;
   // arbitrary neutral identification value
   localparam logic [15:0] TAG_DEFAULT = 16'h5A3C;

   typedef enum logic [0:0] {PWG_BOOT, PWG_READY} pwg_state_t;
endpackage : pwg_pkg

// ==== logic/pwg_std_protect.sv ====
// Purpose: decodes the standard write-protect level for one command
// Assumes: protect byte is the live standard write-protect setting
// Notes:   unknown levels protect nothing
module pwg_std_protect (
   // inputs
   input wire logic [7:0] protectLevel,
   input wire logic [7:0] cmdCode,
   // verdict
   output logic blocked
);
   // ---------------------------------------------------------------
   // level decode
   // ---------------------------------------------------------------
   // the protect command itself always stays writable
   always_comb begin
      blocked = 1'b0;
      if (cmdCode != pwg_pkg::CMD_WRITE_PROTECT) begin
         case (protectLevel)
            pwg_pkg::WP_ALL: blocked = 1'b1;
            pwg_pkg::WP_KEEP_RUN: blocked = (cmdCode != pwg_pkg::CMD_RUN_CTRL);
            pwg_pkg::WP_KEEP_SET: begin
               blocked = (cmdCode != pwg_pkg::CMD_RUN_CTRL) &&
                         (cmdCode != pwg_pkg::CMD_ONOFF_CFG) &&
                         (cmdCode != pwg_pkg::CMD_VOUT_SET);
            end
            default: blocked = 1'b0;
         endcase
      end
   end
endmodule : pwg_std_protect

// ==== tb/pwg_host_model.sv ====
// Purpose: host side issuing word commands to the write guard
// Assumes: the answer lands one cycle after the strobe is taken
// Notes:   released code and data lines show the inverse of the last value
module pwg_host_model (
   // clock
   input wire logic clk_sys,
   // command side
   output logic cmdValid,
   output logic cmdWrite,
   output logic [7:0] cmdCode,
   output logic [15:0] cmdData,
   // answer side
   input wire logic ackValid,
   input wire logic writeGrant,
   input wire logic writeRefused,
   input wire logic [15:0] readData
);
   timeunit 1ns;
   timeprecision 1ns;

   // idle bus at time zero
   initial begin
      cmdValid = 1'b0;
      cmdWrite = 1'b0;
      cmdCode = 8'h00;
      cmdData = 16'h0000;
   end

   // one word transaction; inverted idle lines catch a guard that samples late
   task automatic xfer(input logic wr, input logic [7:0] code, input logic [15:0] data,
         output logic [2:0] verdict, output logic [15:0] rdata);
      @(posedge clk_sys);
      cmdValid <= 1'b1;
      cmdWrite <= wr;
      cmdCode <= code;
      cmdData <= data;
      @(posedge clk_sys);
      cmdValid <= 1'b0;
      cmdCode <= ~code;
      cmdData <= ~data;
      #1;
      verdict = {ackValid, writeGrant, writeRefused};
      rdata = readData;
   endtask : xfer
endmodule : pwg_host_model

// ==== tb/test_pmbus_command_write_guard.sv ====
// Purpose: self-checking bench for the command write guard
// Assumes: answers come one cycle after each strobe
// Notes:   verdict packs ack, grant and refusal into three bits
module test_pmbus_command_write_guard;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [2:0] GRANT = 3'h6;
   localparam logic [2:0] REFUSE = 3'h5;
   localparam logic [2:0] ACKONLY = 3'h4;
   // one governed command for each of lock bits 2 to 8, indexed by bit
   localparam logic [7:0] GRP [2:8] = '{pwg_pkg::CMD_STRAP_BYPASS, pwg_pkg::CMD_MAKER_ID,
      pwg_pkg::CMD_ON_DELAY, pwg_pkg::CMD_IN_UV_WARN, pwg_pkg::CMD_SETUP_FIRST,
      pwg_pkg::CMD_RUN_CTRL, pwg_pkg::CMD_MARGIN_HI};
   logic clk_sys, rst, cmdValid, cmdWrite, nvmLoad, ackValid, writeGrant, writeRefused;
   logic keyOpen, bootDone;
   logic [7:0] cmdCode, protectLevel;
   logic [15:0] cmdData, nvmKeyWord, readData;
   logic [8:0] nvmLockWord, lockBits;
   int badCount = 0;
   int compares = 0;

   pwg_command_write_guard DUT (.clk_sys(clk_sys), .rst(rst), .cmdValid(cmdValid),
      .cmdWrite(cmdWrite), .cmdCode(cmdCode), .cmdData(cmdData), .protectLevel(protectLevel),
      .nvmLoad(nvmLoad), .nvmLockWord(nvmLockWord), .nvmKeyWord(nvmKeyWord),
      .ackValid(ackValid), .writeGrant(writeGrant), .writeRefused(writeRefused),
      .readData(readData), .lockBits(lockBits), .keyOpen(keyOpen), .bootDone(bootDone));
   pwg_host_model host (.clk_sys(clk_sys), .cmdValid(cmdValid), .cmdWrite(cmdWrite),
      .cmdCode(cmdCode), .cmdData(cmdData), .ackValid(ackValid), .writeGrant(writeGrant),
      .writeRefused(writeRefused), .readData(readData));

   // -----------------------------------------------------------
   // helpers
   // -----------------------------------------------------------
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      compares++;
      if (got !== exp) begin
         badCount++;
         $display("BAD %s exp %h got %h", what, exp, got);
      end
   endtask : chk
   task automatic wr(input logic [7:0] c, input logic [15:0] d, input logic [2:0] e);
      logic [2:0] v;
      logic [15:0] r;
      host.xfer(1'b1, c, d, v, r);
      chk("verdict", {13'h0000, e}, {13'h0000, v});
   endtask : wr
   task automatic rd(input logic [7:0] c, input logic [15:0] e);
      logic [2:0] v;
      logic [15:0] r;
      host.xfer(1'b0, c, 16'h0000, v, r);
      chk("verdict", {13'h0000, ACKONLY}, {13'h0000, v});
      chk("readData", e, r);
   endtask : rd
   // backup load: first after reset is boot, later ones restore
   task automatic load(input logic [8:0] lk, input logic [15:0] key);
      @(posedge clk_sys);
      nvmLoad <= 1'b1;
      nvmLockWord <= lk;
      nvmKeyWord <= key;
      @(posedge clk_sys);
      nvmLoad <= 1'b0;
      #1;
   endtask : load
   task automatic protect(input logic [7:0] p);
      @(posedge clk_sys);
      protectLevel <= p;
   endtask : protect
   task automatic doReset();
      @(posedge clk_sys);
      rst <= 1'b1;
      repeat (12) @(posedge clk_sys);
      rst <= 1'b0;
   endtask : doReset
   task automatic summarize();
      if (badCount == 0 && compares > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : summarize

   // -----------------------------------------------------------
   // scenarios
   // -----------------------------------------------------------
   task automatic sBoot();
      wr(pwg_pkg::CMD_RUN_CTRL, 16'h0080, REFUSE);
      rd(pwg_pkg::CMD_TAG, pwg_pkg::TAG_DEFAULT);
      load(9'h000, pwg_pkg::KEY_ZERO);
      chk("bootDone", 16'h0001, {15'h0000, bootDone});
   endtask : sBoot
   // lock bits 2 to 8 each refuse only their own group
   task automatic sGroups();
      for (int b = 2; b <= 8; b++) begin
         wr(pwg_pkg::CMD_LOCK, 16'h0001 << b, GRANT);
         rd(pwg_pkg::CMD_LOCK, 16'h0001 << b);
         for (int k = 2; k <= 8; k++) begin
            wr(GRP[k], 16'h1234, (k == b) ? REFUSE : GRANT);
         end
      end
      wr(pwg_pkg::CMD_LOCK, 16'h0000, GRANT);
      protect(pwg_pkg::WP_ALL);
      wr(pwg_pkg::CMD_MARGIN_HI, 16'h1234, REFUSE);
      // partial protect levels: only the listed commands stay open
      protect(pwg_pkg::WP_KEEP_RUN);
      wr(pwg_pkg::CMD_RUN_CTRL, 16'h0080, GRANT);
      wr(pwg_pkg::CMD_ONOFF_CFG, 16'h0017, REFUSE);
      protect(pwg_pkg::WP_KEEP_SET);
      wr(pwg_pkg::CMD_ONOFF_CFG, 16'h0017, GRANT);
      wr(pwg_pkg::CMD_KEY, 16'h0000, REFUSE);
      wr(pwg_pkg::CMD_MARGIN_HI, 16'h1234, REFUSE);
      protect(8'h00);
      wr(pwg_pkg::CMD_MARGIN_HI, 16'h1234, GRANT);
   endtask : sGroups
   task automatic sTag();
      wr(pwg_pkg::CMD_TAG, 16'hFFFF, ACKONLY);
      rd(pwg_pkg::CMD_TAG, pwg_pkg::TAG_DEFAULT);
   endtask : sTag
   // save lock across live write, restore and standard protect
   task automatic sSave();
      wr(pwg_pkg::CMD_LOCK, 16'h0001, GRANT);
      wr(pwg_pkg::CMD_STORE_ALL, 16'h0000, REFUSE);
      load(9'h000, 16'hBEEF);
      wr(pwg_pkg::CMD_STORE_ALL, 16'h0000, GRANT);
      protect(pwg_pkg::WP_ALL);
      wr(pwg_pkg::CMD_STORE_ALL, 16'h0000, REFUSE);
      protect(8'h00);
      load(9'h001, 16'h0000);
      wr(pwg_pkg::CMD_STORE_ALL, 16'h0000, REFUSE);
      load(9'h002, 16'h0000);
      wr(pwg_pkg::CMD_KEY, 16'h00A5, REFUSE);
      rd(pwg_pkg::CMD_KEY, pwg_pkg::KEY_STAT_OPEN);
   endtask : sSave
   // nonzero boot code shuts the lock word until matched
   task automatic sKey();
      doReset();
      load(9'h000, 16'h00A5);
      rd(pwg_pkg::CMD_KEY, pwg_pkg::KEY_STAT_SHUT);
      wr(pwg_pkg::CMD_LOCK, 16'h0080, REFUSE);
      chk("lockBits", 16'h0000, {7'h00, lockBits});
      wr(pwg_pkg::CMD_STORE_ALL, 16'h0000, REFUSE);
      wr(pwg_pkg::CMD_KEY, 16'h00A5, GRANT);
      chk("keyOpen", 16'h0001, {15'h0000, keyOpen});
      wr(pwg_pkg::CMD_LOCK, 16'h0002, GRANT);
      doReset();
      load(9'h002, 16'h00A5);
      wr(pwg_pkg::CMD_KEY, 16'h00A5, REFUSE);
      wr(pwg_pkg::CMD_LOCK, 16'h0000, REFUSE);
      chk("lockBits", 16'h0002, {7'h00, lockBits});
   endtask : sKey

   // clock at 50 ns period
   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end
   // hang guard
   initial begin
      repeat (20000) @(posedge clk_sys);
      badCount++;
      summarize();
   end
   // main sequence
   initial begin
      rst = 1'b1;
      nvmLoad = 1'b0;
      nvmLockWord = 9'h000;
      nvmKeyWord = 16'h0000;
      protectLevel = 8'h00;
      repeat (12) @(posedge clk_sys);
      rst <= 1'b0;
      sBoot();
      sGroups();
      sTag();
      sSave();
      sKey();
      summarize();
   end
endmodule : test_pmbus_command_write_guard
